// >>> hw/cemc_regs.sv
// Enhanced level-control and misc control register group with its control decode
// Notes on behaviour
// [R01] Level register one bit 6 picks default or alternate target level table.
// [R02] Level register one bit 7 picks peak or peak-to-peak for threshold logic.
// [R03] Level register one bit 8 picks peak or peak-to-peak for noise gate.
// [R04] Fast limiter disable bit is active low enable; reset leaves limiter on.
// [R05] Oversample force bit set means 256x regardless of other rate select.
// [R06] Unlocked PLL output blocked unless unlocked pass bit is set.
// [R07] Exact mute bit forces DAC output to zero while softmute active.
// [R08] Notch output used after 512 samples unless no-delay bit set.
// [R09] Short frame detection enabled when its disable bit is zero.
// [R10] Flush bit makes a short frame event reset DSP state.
// [R11] Short frame when frame under 255, 253, 254 or 255 clocks by field.
// [R12] SPI force bit selects four-wire 24-bit SPI whatever the mode pin.
// [R13] Without force, mode pin low gives two-wire, high gives 16-bit SPI.
// [R14] Manual reference switch bits close switches; else power register decides.
// [R15] Tie-off bit 7 selects two or three speaker amplifier stages.
// [R16] Peak-to-peak register reads the current amplitude register in bits 0..8.
// [R17] Both channels controlled: report larger of left and right amplitude.
// [R18] Undefined bits read zero and ignore writes.
`timescale 1ns/1ps
module cemc_regs
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Decoded register access from the serial control port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  // Level-control datapath
  input wire logic [5:0] lvl_gain,
  input wire logic [8:0] p2p_left,
  input wire logic [8:0] p2p_right,
  input wire logic both_channels,
  output logic target_table_select,
  output logic threshold_detector_select,
  output logic gate_detector_select,
  output logic fast_limiter_on,
  // DAC and PLL
  input wire logic dac_rate_sel,
  input wire logic pll_locked,
  input wire logic softmute_active,
  output logic dac_os256,
  output logic vco_out_enable,
  output logic dac_force_zero,
  // Notch filter
  input wire logic notch_enable,
  input wire logic sample_tick,
  output logic notch_out_use,
  // Frame sync supervision
  input wire logic frame_sync,
  output logic short_frame_event,
  output logic dsp_flush,
  // Control port mode
  input wire logic mode_pin,
  output logic ctrl_spi_mode,
  output logic ctrl_spi_24bit,
  // Analog switches
  input wire logic [2:0] pwr_ref_switch,
  output logic [2:0] ref_switch_close,
  output logic speaker_stage_select
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] lock_sync;
  logic [1:0] mode_sync;
  logic [1:0] fs_sync;
  logic fs_last;
  logic [1:0] next_lock_sync;
  logic [1:0] next_mode_sync;
  logic [1:0] next_fs_sync;
  logic next_fs_last;
  logic fs_rise;

  always_comb
  begin
    next_lock_sync = {lock_sync[0], pll_locked};
    next_mode_sync = {mode_sync[0], mode_pin};
    next_fs_sync = {fs_sync[0], frame_sync};
    next_fs_last = fs_sync[1];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_sync <= 2'h0;
      mode_sync <= 2'h0;
      fs_sync <= 2'h0;
      fs_last <= 1'b0;
    end
    else if (clk_en)
    begin
      lock_sync <= next_lock_sync;
      mode_sync <= next_mode_sync;
      fs_sync <= next_fs_sync;
      fs_last <= next_fs_last;
    end
  end

  // Edge is taken from the second and third stage only
  assign fs_rise = fs_sync[1] & ~fs_last;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [8:0] lvl_one;
  logic [8:0] lvl_two;
  logic [8:0] misc;
  logic [8:0] tie_off;
  logic [8:0] p2p_hold;
  logic [5:0] gain_hold;
  logic [8:0] next_lvl_one;
  logic [8:0] next_lvl_two;
  logic [8:0] next_misc;
  logic [8:0] next_tie_off;
  logic [8:0] next_p2p_hold;
  logic [5:0] next_gain_hold;
  logic [8:0] next_rdata;

  always_comb
  begin
    next_lvl_one = lvl_one;
    next_lvl_two = lvl_two;
    next_misc = misc;
    next_tie_off = tie_off;
    next_gain_hold = lvl_gain;
    // Larger channel only when both are under level control
    if (both_channels && (p2p_right > p2p_left)) // [R17]
      next_p2p_hold = p2p_right;
    else
      next_p2p_hold = p2p_left; // [R16]
    if (reg_wr)
    begin
      case (reg_addr)
        cemc_pkg::ADDR_LVL_ONE: next_lvl_one = reg_wdata & cemc_pkg::MASK_LVL_ONE; // [R18]
        cemc_pkg::ADDR_LVL_TWO: next_lvl_two = reg_wdata & cemc_pkg::MASK_LVL_TWO; // [R18]
        cemc_pkg::ADDR_MISC: next_misc = reg_wdata & cemc_pkg::MASK_MISC;
        cemc_pkg::ADDR_TIE_OFF: next_tie_off = reg_wdata & cemc_pkg::MASK_TIE_OFF; // [R18]
        default: next_misc = misc;
      endcase
    end
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        cemc_pkg::ADDR_LVL_ONE: next_rdata = {lvl_one[8:6], gain_hold};
        cemc_pkg::ADDR_LVL_TWO: next_rdata = lvl_two;
        cemc_pkg::ADDR_MISC: next_rdata = misc;
        cemc_pkg::ADDR_TIE_OFF: next_rdata = tie_off;
        cemc_pkg::ADDR_P2P: next_rdata = p2p_hold; // [R16]
        default: next_rdata = 9'h000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lvl_one <= cemc_pkg::RST_LVL_ONE & cemc_pkg::MASK_LVL_ONE;
      gain_hold <= cemc_pkg::RST_LVL_ONE[cemc_pkg::LVL1_GAIN_MSB:0];
      lvl_two <= cemc_pkg::RST_LVL_TWO; // [R04]
      misc <= cemc_pkg::RST_MISC;
      tie_off <= cemc_pkg::RST_TIE_OFF;
      p2p_hold <= cemc_pkg::RST_P2P;
      reg_rdata <= 9'h000;
    end
    else if (clk_en)
    begin
      lvl_one <= next_lvl_one;
      gain_hold <= next_gain_hold;
      lvl_two <= next_lvl_two;
      misc <= next_misc;
      tie_off <= next_tie_off;
      p2p_hold <= next_p2p_hold;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Notch filter settling delay
  // ----------------------------------------------------------------
  logic [9:0] notch_cnt;
  logic [9:0] next_notch_cnt;
  logic next_notch_use;

  always_comb
  begin
    next_notch_cnt = notch_cnt;
    if (!notch_enable)
      next_notch_cnt = 10'h000;
    else if (sample_tick && (notch_cnt != cemc_pkg::NOTCH_DELAY_SAMPLES))
      next_notch_cnt = notch_cnt + 10'h001;
    // Bypassing the delay trades the settling transient for immediate effect
    next_notch_use = notch_enable & (misc[cemc_pkg::MISC_NOTCH_NODLY_BIT] |
                     (notch_cnt == cemc_pkg::NOTCH_DELAY_SAMPLES)); // [R08]
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      notch_cnt <= 10'h000;
      notch_out_use <= 1'b0;
    end
    else if (clk_en)
    begin
      notch_cnt <= next_notch_cnt;
      notch_out_use <= next_notch_use;
    end
  end

  // ----------------------------------------------------------------
  // Short frame sync detection
  // ----------------------------------------------------------------
  logic [8:0] frame_cnt;
  logic frame_seen;
  logic [8:0] next_frame_cnt;
  logic next_frame_seen;
  logic [8:0] sf_limit;
  logic next_short;
  logic next_flush;

  always_comb
  begin
    case (misc[cemc_pkg::MISC_SF_THR_LSB +: 2]) // [R11]
      2'h0: sf_limit = cemc_pkg::SF_LIMIT_00;
      2'h1: sf_limit = cemc_pkg::SF_LIMIT_01;
      2'h2: sf_limit = cemc_pkg::SF_LIMIT_10;
      default: sf_limit = cemc_pkg::SF_LIMIT_11;
    endcase
    next_frame_cnt = frame_cnt;
    next_frame_seen = frame_seen;
    next_short = 1'b0;
    if (fs_rise)
    begin
      // The first edge after reset has no previous frame to measure
      next_short = frame_seen & (frame_cnt < sf_limit) &
                   ~misc[cemc_pkg::MISC_SF_DIS_BIT]; // [R09] [R11]
      next_frame_cnt = 9'h001;
      next_frame_seen = 1'b1;
    end
    else if (frame_cnt != cemc_pkg::SF_COUNT_MAX)
      next_frame_cnt = frame_cnt + 9'h001;
    next_flush = next_short & misc[cemc_pkg::MISC_SF_FLUSH_BIT]; // [R10]
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_cnt <= 9'h000;
      frame_seen <= 1'b0;
      short_frame_event <= 1'b0;
      dsp_flush <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_cnt <= next_frame_cnt;
      frame_seen <= next_frame_seen;
      short_frame_event <= next_short;
      dsp_flush <= next_flush;
    end
  end

  // ----------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------
  logic next_table;
  logic next_thr_sel;
  logic next_gate_sel;
  logic next_lim_on;
  logic next_os256;
  logic next_vco_en;
  logic next_force_zero;
  logic next_spi_mode;
  logic next_spi_24;
  logic [2:0] next_ref_close;
  logic next_spk_stage;

  always_comb
  begin
    next_table = lvl_one[cemc_pkg::LVL1_TABLE_BIT]; // [R01]
    next_thr_sel = lvl_one[cemc_pkg::LVL1_THR_SEL_BIT]; // [R02]
    next_gate_sel = lvl_one[cemc_pkg::LVL1_GATE_SEL_BIT]; // [R03]
    next_lim_on = ~lvl_two[cemc_pkg::LVL2_LIM_DIS_BIT]; // [R04]
    next_os256 = misc[cemc_pkg::MISC_OS256_BIT] | dac_rate_sel; // [R05]
    next_vco_en = lock_sync[1] | misc[cemc_pkg::MISC_VCO_PASS_BIT]; // [R06]
    next_force_zero = misc[cemc_pkg::MISC_EXACT_MUTE_BIT] & softmute_active; // [R07]
    next_spi_mode = misc[cemc_pkg::MISC_SPI_FORCE_BIT] | mode_sync[1]; // [R12] [R13]
    next_spi_24 = misc[cemc_pkg::MISC_SPI_FORCE_BIT]; // [R12]
    next_ref_close = tie_off[cemc_pkg::TIE_REF_LSB +: 3] | pwr_ref_switch; // [R14]
    next_spk_stage = tie_off[cemc_pkg::TIE_SPK_STAGE_BIT]; // [R15]
  end

  // Mode resets low and follows the pin three clocks after reset release, behind the two-stage synchroniser
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      target_table_select <= 1'b0;
      threshold_detector_select <= 1'b0;
      gate_detector_select <= 1'b0;
      fast_limiter_on <= 1'b1;
      dac_os256 <= 1'b0;
      vco_out_enable <= 1'b0;
      dac_force_zero <= 1'b0;
      ctrl_spi_mode <= 1'b0;
      ctrl_spi_24bit <= 1'b0;
      ref_switch_close <= 3'h0;
      speaker_stage_select <= 1'b0;
    end
    else if (clk_en)
    begin
      target_table_select <= next_table;
      threshold_detector_select <= next_thr_sel;
      gate_detector_select <= next_gate_sel;
      fast_limiter_on <= next_lim_on;
      dac_os256 <= next_os256;
      vco_out_enable <= next_vco_en;
      dac_force_zero <= next_force_zero;
      ctrl_spi_mode <= next_spi_mode;
      ctrl_spi_24bit <= next_spi_24;
      ref_switch_close <= next_ref_close;
      speaker_stage_select <= next_spk_stage;
    end
  end

endmodule

// >>> inc/cemc_pkg.sv
// Constants for the enhanced level-control and misc control register group
package cemc_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_LVL_ONE = 7'h46;
  localparam logic [6:0] ADDR_LVL_TWO = 7'h47;
  localparam logic [6:0] ADDR_MISC = 7'h49;
  localparam logic [6:0] ADDR_TIE_OFF = 7'h4b;
  localparam logic [6:0] ADDR_P2P = 7'h4c;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] RST_LVL_ONE = 9'h001;
  localparam logic [8:0] RST_LVL_TWO = 9'h000;
  localparam logic [8:0] RST_MISC = 9'h000;
  localparam logic [8:0] RST_TIE_OFF = 9'h000;
  localparam logic [8:0] RST_P2P = 9'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LVL1_GAIN_MSB = 5;
  localparam int LVL1_TABLE_BIT = 6;
  localparam int LVL1_THR_SEL_BIT = 7;
  localparam int LVL1_GATE_SEL_BIT = 8;
  localparam int LVL2_LIM_DIS_BIT = 8;
  localparam int MISC_OS256_BIT = 0;
  localparam int MISC_VCO_PASS_BIT = 1;
  localparam int MISC_EXACT_MUTE_BIT = 2;
  localparam int MISC_NOTCH_NODLY_BIT = 3;
  localparam int MISC_SF_DIS_BIT = 4;
  localparam int MISC_SF_FLUSH_BIT = 5;
  localparam int MISC_SF_THR_LSB = 6;
  localparam int MISC_SPI_FORCE_BIT = 8;
  localparam int TIE_REF_LSB = 0;
  localparam int TIE_SPK_STAGE_BIT = 7;

  // Writable bits of each register; the rest read zero, except level register one bits 0..5, which read the gain
  localparam logic [8:0] MASK_LVL_ONE = 9'h1c0;
  localparam logic [8:0] MASK_LVL_TWO = 9'h100;
  localparam logic [8:0] MASK_MISC = 9'h1ff;
  localparam logic [8:0] MASK_TIE_OFF = 9'h087;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [9:0] NOTCH_DELAY_SAMPLES = 10'h200;
  localparam logic [8:0] SF_LIMIT_00 = 9'h0ff;
  localparam logic [8:0] SF_LIMIT_01 = 9'h0fd;
  localparam logic [8:0] SF_LIMIT_10 = 9'h0fe;
  localparam logic [8:0] SF_LIMIT_11 = 9'h0ff;
  localparam logic [8:0] SF_COUNT_MAX = 9'h1ff;
endpackage

// >>> test/cemc_host.sv
// Host model that issues decoded register writes and reads
`timescale 1ns/1ps
module cemc_host
(
  // Clock
  input wire logic clk_sys,
  // Decoded register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [8:0] reg_wdata,
  input wire logic [8:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
  end
  // ------
  // Accesses look the same whatever bus mode the pin picks
  // ------
  // Released lines show inverted leftovers so a stale word never passes
  task automatic wr(logic [6:0] a, logic [8:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(logic [6:0] a, output logic [8:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

// >>> test/cemc_regs_chk.sv
// Assertion checker for the level-control and misc control registers
`timescale 1ns/1ps
module cemc_regs_chk
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic [8:0] reg_rdata,
  // Datapath inputs
  input wire logic [8:0] p2p_left,
  input wire logic [8:0] p2p_right,
  input wire logic both_channels,
  input wire logic softmute_active,
  input wire logic notch_enable,
  // Controls
  input wire logic target_table_select,
  input wire logic fast_limiter_on,
  input wire logic dac_os256,
  input wire logic dac_force_zero,
  input wire logic notch_out_use,
  input wire logic short_frame_event,
  input wire logic dsp_flush,
  input wire logic ctrl_spi_mode,
  input wire logic ctrl_spi_24bit,
  input wire logic [2:0] ref_switch_close
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic [8:0] p2p_q;
  logic [8:0] next_p2p_q;
  // Amplitude the read path should have captured one cycle before the read
  always_comb
    next_p2p_q = (both_channels && p2p_right > p2p_left) ? p2p_right : p2p_left;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      p2p_q <= 9'h000;
    else
      p2p_q <= next_p2p_q;
  // ------
  // Assertions
  // ------
  sequence s_wr(logic [6:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_table_follow: assert property (
    s_wr(cemc_pkg::ADDR_LVL_ONE) |=> ##1 target_table_select == $past(reg_wdata[6], 2))
    else $error("table select wrong");
  a_limiter_low: assert property (
    s_wr(cemc_pkg::ADDR_LVL_TWO) |=> ##1 fast_limiter_on == !$past(reg_wdata[8], 2))
    else $error("limiter enable wrong");
  a_os256_force: assert property (
    s_wr(cemc_pkg::ADDR_MISC) ##0 reg_wdata[0] |=> ##1 dac_os256)
    else $error("oversample force ignored");
  a_spi_force: assert property (
    s_wr(cemc_pkg::ADDR_MISC) ##0 reg_wdata[8] |=> ##1 ctrl_spi_mode && ctrl_spi_24bit)
    else $error("spi force ignored");
  a_ref_close: assert property (
    s_wr(cemc_pkg::ADDR_TIE_OFF) |=> ##1 (ref_switch_close | ~$past(reg_wdata[2:0], 2)) == 3'h7)
    else $error("manual switch not closed");
  a_zero_mute: assert property (dac_force_zero |-> $past(softmute_active))
    else $error("zero forced without softmute");
  a_flush_pair: assert property (dsp_flush |-> short_frame_event)
    else $error("flush without short frame");
  a_notch_hold: assert property (
    notch_out_use |-> $past(notch_enable) || $past(notch_enable, 2))
    else $error("notch output used while disabled");
  a_p2p_read: assert property (
    reg_rd && reg_addr == cemc_pkg::ADDR_P2P |=> reg_rdata == $past(p2p_q))
    else $error("peak-to-peak readback wrong");
endmodule
bind cemc_regs cemc_regs_chk chk_u (.*);

// >>> test/tb_cemc_regs.sv
// Self-checking bench for the level-control and misc control registers
`timescale 1ns/1ps
module tb_cemc_regs;
  typedef struct {logic [6:0] a; logic [8:0] w; logic [8:0] r;} cemc_row_s;
  logic clk_sys, arst_n, clk_en, reg_wr, reg_rd, both_channels, dac_rate_sel, pll_locked;
  logic softmute_active, notch_enable, sample_tick, frame_sync, mode_pin;
  logic target_table_select, threshold_detector_select, gate_detector_select, fast_limiter_on;
  logic dac_os256, vco_out_enable, dac_force_zero, notch_out_use, short_frame_event, dsp_flush;
  logic ctrl_spi_mode, ctrl_spi_24bit, speaker_stage_select;
  logic [6:0] reg_addr;
  logic [5:0] lvl_gain;
  logic [8:0] reg_wdata, reg_rdata, p2p_left, p2p_right, rd;
  logic [2:0] pwr_ref_switch, ref_switch_close;
  int fails, total_checks, cyc, evs, fls, lim;
  // Unmapped 0x48 and read-only 0x4c swallow their writes
  cemc_row_s rows[6] = '{'{7'h46, 9'h1ff, 9'h1d5}, '{7'h47, 9'h1ff, 9'h100}, '{7'h49, 9'h1ff, 9'h1ff},
    '{7'h4b, 9'h1ff, 9'h087}, '{7'h48, 9'h1ff, 9'h000}, '{7'h4c, 9'h1ff, 9'h0aa}};
  cemc_regs dut_u (.*);
  cemc_host host_u (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
  begin
    cyc++;
    evs += int'(short_frame_event);
    fls += int'(dsp_flush);
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(string name, logic [8:0] seen, logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic tick(int n);
    repeat (n)
    begin
      sample_tick = 1'b1;
      wait_cyc(1);
      sample_tick = 1'b0;
      wait_cyc(1);
    end
  endtask
  // Three rises n cycles apart give two frames of length n
  task automatic frames(int n);
    repeat (3)
    begin
      frame_sync = 1'b1;
      wait_cyc(4);
      frame_sync = 1'b0;
      wait_cyc(n - 4);
    end
    wait_cyc(8);
  endtask
  // ------
  // Stimulus
  // ------
  initial
  begin
    {arst_n, both_channels, dac_rate_sel, pll_locked, mode_pin} = 5'h00;
    {notch_enable, sample_tick, frame_sync, p2p_left, p2p_right} = 21'h000000;
    {clk_en, softmute_active, lvl_gain, pwr_ref_switch} = {2'b11, 6'h01, 3'b010};
    wait_cyc(2);
    arst_n = 1'b1;
    chk("reset limiter", 9'(fast_limiter_on), 9'h001);
    foreach (rows[i])
    begin
      host_u.rd(rows[i].a, rd);
      chk("reset value", rd, rows[i].a == 7'h46 ? 9'h001 : 9'h000);
    end
    {lvl_gain, p2p_left} = {6'h15, 9'h0aa};
    foreach (rows[i])
    begin
      host_u.wr(rows[i].a, rows[i].w);
      host_u.rd(rows[i].a, rd);
      chk("readback", rd, rows[i].r);
    end
    for (int v = 0; v < 2; v++)
    begin
      host_u.wr(7'h46, v ? 9'h1c0 : 9'h000);
      host_u.wr(7'h47, {v[0], 8'h00});
      host_u.wr(7'h49, v ? 9'h107 : 9'h000);
      host_u.wr(7'h4b, v ? 9'h087 : 9'h000);
      wait_cyc(3);
      chk("selects", 9'({target_table_select, threshold_detector_select, gate_detector_select}), 9'({3{v[0]}}));
      chk("limiter", 9'(fast_limiter_on), 9'(!v[0]));
      chk("misc", 9'({dac_os256, vco_out_enable, dac_force_zero, ctrl_spi_mode, ctrl_spi_24bit}), 9'({5{v[0]}}));
      chk("switches", 9'({speaker_stage_select, ref_switch_close}), v ? 9'h00f : 9'h002);
    end
    // Clear the force bits so the pins alone decide
    host_u.wr(7'h49, 9'h000);
    {mode_pin, dac_rate_sel, pll_locked} = 3'b111;
    wait_cyc(6);
    chk("pins", 9'({ctrl_spi_mode, ctrl_spi_24bit, dac_os256, vco_out_enable, dac_force_zero}), 9'h016);
    for (int k = 0; k < 3; k++)
    begin
      p2p_left = k == 2 ? 9'h1f0 : 9'h123;
      p2p_right = k == 2 ? 9'h00f : 9'h1aa;
      both_channels = k != 0;
      host_u.rd(7'h4c, rd);
      chk("p2p", rd, k == 1 ? 9'h1aa : p2p_left);
    end
    notch_enable = 1'b1;
    tick(511);
    chk("notch early", 9'(notch_out_use), 9'h000);
    tick(1);
    wait_cyc(2);
    chk("notch after 512", 9'(notch_out_use), 9'h001);
    notch_enable = 1'b0;
    host_u.wr(7'h49, 9'h008);
    notch_enable = 1'b1;
    wait_cyc(3);
    chk("notch at once", 9'(notch_out_use), 9'h001);
    notch_enable = 1'b0;
    fls = 0;
    for (int c = 0; c < 4; c++)
    begin
      lim = c == 1 ? 253 : c == 2 ? 254 : 255;
      host_u.wr(7'h49, 9'(c << 6));
      for (int s = 0; s < 2; s++)
      begin
        evs = 0;
        frames(lim - 1 + s);
        chk("short frames", 9'(evs), s ? 9'h000 : 9'h002);
      end
    end
    chk("no flush", 9'(fls), 9'h000);
    host_u.wr(7'h49, 9'h020);
    fls = 0;
    frames(200);
    chk("flush", 9'(fls), 9'h002);
    host_u.wr(7'h49, 9'h030);
    evs = 0;
    frames(200);
    chk("detect off", 9'(evs), 9'h000);
    // Mid-run reset must bring back the limiter and clear the misc word
    arst_n = 1'b0;
    wait_cyc(2);
    chk("mid reset limiter", 9'(fast_limiter_on), 9'h001);
    arst_n = 1'b1;
    host_u.rd(7'h49, rd);
    chk("mid reset misc", rd, 9'h000);
    report_and_stop();
  end
endmodule
